// [hdl/pbsp_defines.svh]
// Constants for the pipelined burst SRAM port: widths, depth, reset values
`ifndef PBSP_DEFINES_SVH
`define PBSP_DEFINES_SVH

`define PBSP_ADDR_W      16
`define PBSP_DATA_W      32
`define PBSP_LANES       4
`define PBSP_LANE_W      8
`define PBSP_DEPTH       65536
`define PBSP_STEP_W      2
`define PBSP_STEP_RST    2'h0
`define PBSP_ADDR_RST    16'h0000
`define PBSP_DATA_RST    32'h0000_0000
`define PBSP_SYNC_STAGES 2

`endif

// [hdl/pbsp_pkg.sv]
// Types shared by the pipelined burst SRAM port
`include "pbsp_defines.svh"

package pbsp_pkg;

	typedef logic [`PBSP_ADDR_W-1:0] pbsp_addr_t;
	typedef logic [`PBSP_DATA_W-1:0] pbsp_word_t;
	typedef logic [`PBSP_LANES-1:0]  pbsp_lanes_t;
	typedef logic [`PBSP_STEP_W-1:0] pbsp_step_t;

	// Burst order as picked by the strap pin
	typedef enum logic
	{
		PBSP_ORDER_LINEAR      = 1'b0,
		PBSP_ORDER_INTERLEAVED = 1'b1
	} pbsp_order_t;

endpackage

// [hdl/pbsp_mem.sv]
// Storage array of 64K words by 32 bits with byte-lane writes and a registered read
`timescale 1ns/1ps
`include "pbsp_defines.svh"

module pbsp_mem
(
	input  logic                  core_clk,
	input  logic                  clk_en,
	input  pbsp_pkg::pbsp_addr_t  addr,
	input  pbsp_pkg::pbsp_lanes_t wr_lane,
	input  pbsp_pkg::pbsp_word_t  wr_data,
	input  logic                  rd_en,
	output pbsp_pkg::pbsp_word_t  rd_data_r
);
	import pbsp_pkg::*;

	// Contents are never reset, the array only keeps what was written
	pbsp_word_t mem_r [0:`PBSP_DEPTH-1];

	// Self-timed write: each enabled lane is stored on the same edge, no write pulse needed
	always_ff @(posedge core_clk)
	begin
		if (clk_en)
		begin
			for (int i = 0; i < `PBSP_LANES; i++)
			begin
				if (wr_lane[i])
					mem_r[addr][i*`PBSP_LANE_W +: `PBSP_LANE_W] <= wr_data[i*`PBSP_LANE_W +: `PBSP_LANE_W];
			end
		end
	end

	// Output register of the pipelined read path
	always_ff @(posedge core_clk)
	begin
		if (clk_en && rd_en)
			rd_data_r <= mem_r[addr];
	end

endmodule

// [hdl/pbsp_port.sv]
// Synchronous port of a 64K by 32 pipelined burst cache SRAM
`timescale 1ns/1ps
`include "pbsp_defines.svh"

// Overview of operation
// - All synchronous inputs are taken on the rising clock edge, set up by the far side.
// - Read data leaves through an output register clocked on the rising edge.
// - Storage is 64K words of 32 bits behind a shared two-way data path.
// - The 16-bit address is captured on a strobe only while all chip selects are active.
// - Either the processor or the controller address strobe starts an access.
// - The processor strobe is ignored while chip select one is high.
// - The two lowest address bits load the burst counter at address capture.
// - The burst counter holds the start and forms later addresses, wrapping in two bits.
// - In an open burst the counter steps on each edge with burst advance low, deselecting strobe edges included; a selected strobe clears it, otherwise it holds.
// - The order-select strap picks interleaved or linear burst order.
// - A byte write stores only lanes whose select is low, and only with gate low.
// - Global write low stores all four bytes, whatever the lane and gate inputs.
// - Writes finish internally on the clock edge, no external write pulse exists.
// - Selected only with select one low, select two high, select three low.
// - Output enable is masked on the first read clock after a deselect.
// - With both strobes low and select one low at one edge only the processor strobe counts.
// - Strap low means linear order, strap high or floating means interleaved.
// - Data out shows the location addressed at the previous edge, one stage of latency.
// - A high sleep request idles the device while keeping its contents.

module pbsp_port
(
	core_clk,
	rstn,
	clk_en,
	addr,
	processor_addr_strobe_n,
	controller_addr_strobe_n,
	burst_advance_n,
	byte_lane_select_n,
	byte_write_gate_n,
	global_write_all_n,
	chip_select_one_n,
	chip_select_two,
	chip_select_three_n,
	output_enable_n,
	order_select,
	sleep_request,
	dq_in,
	dq_out,
	dq_oe_n,
	sleep_active,
	burst_active
);
	import pbsp_pkg::*;

	input  logic                  core_clk;
	input  logic                  rstn;
	input  logic                  clk_en;
	input  pbsp_pkg::pbsp_addr_t  addr;
	input  logic                  processor_addr_strobe_n;
	input  logic                  controller_addr_strobe_n;
	input  logic                  burst_advance_n;
	input  pbsp_pkg::pbsp_lanes_t byte_lane_select_n;
	input  logic                  byte_write_gate_n;
	input  logic                  global_write_all_n;
	input  logic                  chip_select_one_n;
	input  logic                  chip_select_two;
	input  logic                  chip_select_three_n;
	input  logic                  output_enable_n;
	input  logic                  order_select;
	input  logic                  sleep_request;
	input  pbsp_pkg::pbsp_word_t  dq_in;
	output pbsp_pkg::pbsp_word_t  dq_out;
	output logic                  dq_oe_n;
	output logic                  sleep_active;
	output logic                  burst_active;

	// Burst address low bits from start value and step count
	function automatic pbsp_step_t burst_low(input pbsp_step_t start, input pbsp_step_t step,
		input pbsp_order_t order);
		pbsp_step_t res;
		res = start ^ step;
		if (order == PBSP_ORDER_LINEAR)
			res = start + step;
		return res;
	endfunction

	// Two-flop synchronisers for the pins not tied to core_clk timing
	logic [`PBSP_SYNC_STAGES-1:0] sleep_sync_r;
	logic [`PBSP_SYNC_STAGES-1:0] order_sync_r;
	pbsp_order_t                  order_r;

	// Access state
	pbsp_addr_t                   base_r;
	pbsp_step_t                   start_r;
	pbsp_step_t                   step_r;
	logic                         active_r;
	logic                         desel_r;
	logic                         from_desel_r;
	logic                         drive_r;
	logic                         oe_mask_r;

	// Decoded strobes and controls of the current edge
	logic                         selected;
	logic                         proc_strobe;
	logic                         ctrl_strobe;
	logic                         any_strobe;
	logic                         sleeping;
	pbsp_lanes_t                  lane_wr;
	pbsp_lanes_t                  mem_lane;
	logic                         do_write;
	logic                         do_read;
	pbsp_addr_t                   cur_addr;

	// Sleep pin and strap cross in through two flops; the first stage feeds only the second
	always_ff @(posedge core_clk)
	begin
		if (!rstn)
		begin
			sleep_sync_r <= '0;
			order_sync_r <= '0;
		end
		else if (clk_en)
		begin
			sleep_sync_r <= {sleep_sync_r[0], sleep_request};
			order_sync_r <= {order_sync_r[0], order_select};
		end
	end

	// Strap decode; a floating strap is pulled high outside, giving interleaved order
	always_ff @(posedge core_clk)
	begin
		if (!rstn)
			order_r <= PBSP_ORDER_INTERLEAVED;
		else if (clk_en)
			order_r <= order_sync_r[1] ? PBSP_ORDER_INTERLEAVED : PBSP_ORDER_LINEAR;
	end

	// Control decode, all sampled at the rising edge that the flops below use
	always_comb
	begin
		sleeping    = sleep_sync_r[1];
		selected    = !chip_select_one_n && chip_select_two && !chip_select_three_n;
		proc_strobe = !processor_addr_strobe_n && !chip_select_one_n;
		ctrl_strobe = !controller_addr_strobe_n && !proc_strobe;
		any_strobe  = (proc_strobe || ctrl_strobe) && !sleeping;
	end

	// Lane enables: global write overrides lane selects and the gate
	always_comb
	begin
		lane_wr = '0;
		if (!byte_write_gate_n)
			lane_wr = ~byte_lane_select_n;
		if (!global_write_all_n)
			lane_wr = '1;
	end

	// Writes and reads use the address held from earlier edges; strobe edges load it and block writes, but an open burst still reads there
	always_comb
	begin
		do_write = active_r && !any_strobe && !sleeping && (lane_wr != '0);
		do_read  = active_r && !sleeping && !do_write;
		mem_lane = do_write ? lane_wr : '0;
		cur_addr = {base_r[`PBSP_ADDR_W-1:`PBSP_STEP_W], burst_low(start_r, step_r, order_r)};
	end

	// Address register, captured only on a strobe with the chip selected
	always_ff @(posedge core_clk)
	begin
		if (!rstn)
		begin
			base_r  <= `PBSP_ADDR_RST;
			start_r <= `PBSP_STEP_RST;
		end
		else if (clk_en && any_strobe && selected)
		begin
			base_r  <= addr;
			start_r <= addr[`PBSP_STEP_W-1:0];
		end
	end

	// Burst step counter wraps in two bits since it never carries into the base
	always_ff @(posedge core_clk)
	begin
		if (!rstn)
			step_r <= `PBSP_STEP_RST;
		else if (clk_en)
		begin
			if (any_strobe && selected)
				step_r <= `PBSP_STEP_RST;
			else if (active_r && !sleeping && !burst_advance_n)
				step_r <= step_r + 2'h1;
		end
	end

	// Selection state; a strobe with the chip not selected deselects it
	always_ff @(posedge core_clk)
	begin
		if (!rstn)
		begin
			active_r     <= 1'b0;
			desel_r      <= 1'b1;
			from_desel_r <= 1'b0;
		end
		else if (clk_en)
		begin
			if (sleeping)
			begin
				// Sleep ends the burst, contents in the array stay intact
				active_r <= 1'b0;
				desel_r  <= 1'b1;
			end
			else if (any_strobe)
			begin
				active_r     <= selected;
				desel_r      <= !selected;
				from_desel_r <= selected && desel_r;
			end
			else if (do_read || do_write)
				from_desel_r <= 1'b0;
		end
	end

	// Driving window and the output-enable mask for the first read after a deselect
	always_ff @(posedge core_clk)
	begin
		if (!rstn)
		begin
			drive_r   <= 1'b0;
			oe_mask_r <= 1'b0;
		end
		else if (clk_en)
		begin
			drive_r   <= do_read;
			oe_mask_r <= do_read && from_desel_r;
		end
	end

	// Storage array; its read register doubles as the data output register
	pbsp_mem u_mem
	(
		.core_clk  (core_clk),
		.clk_en    (clk_en),
		.addr      (cur_addr),
		.wr_lane   (mem_lane),
		.wr_data   (dq_in),
		.rd_en     (do_read),
		.rd_data_r (dq_out)
	);

	// Output enable stays asynchronous, so the pin gate is combinational on purpose
	assign dq_oe_n      = output_enable_n || oe_mask_r || !drive_r;
	assign sleep_active = sleeping;
	assign burst_active = active_r;

endmodule

// [bench/pbsp_port_assertions.sv]
// Pin-level checks on the burst SRAM port
`timescale 1ns/1ps
module pbsp_chk
(
	input logic core_clk,
	input logic rstn,
	input logic clk_en,
	input logic processor_addr_strobe_n,
	input logic controller_addr_strobe_n,
	input logic byte_write_gate_n,
	input logic global_write_all_n,
	input logic chip_select_one_n,
	input logic chip_select_two,
	input logic chip_select_three_n,
	input logic output_enable_n,
	input logic sleep_request,
	input logic dq_oe_n,
	input logic sleep_active,
	input logic burst_active
);
	import pbsp_pkg::*;
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!rstn);
	// Strobe as the port sees it, select pattern, and an edge that may act
	wire stb = (!processor_addr_strobe_n && !chip_select_one_n) || !controller_addr_strobe_n;
	wire sel = !chip_select_one_n && chip_select_two && !chip_select_three_n;
	wire go = clk_en && !sleep_active;
	sequence s_open;
		go && stb && sel;
	endsequence
	sequence s_read;
		go && burst_active && !stb && global_write_all_n && byte_write_gate_n;
	endsequence
	open_next_a : assert property (s_open |=> burst_active)
		else $error("selected strobe left burst closed");
	desel_close_a : assert property (go && stb && !sel |=> !burst_active)
		else $error("deselecting strobe left burst open");
	proc_ignore_a : assert property (go && burst_active && chip_select_one_n
		&& !processor_addr_strobe_n && controller_addr_strobe_n |=> burst_active)
		else $error("processor strobe taken with select one high");
	mask_first_a : assert property (!burst_active ##0 s_open ##1 s_read |=> dq_oe_n)
		else $error("first read after deselect drove the bus");
	read_drive_a : assert property (s_read ##1 s_read |=> output_enable_n || !dq_oe_n)
		else $error("read data not driven");
	write_quiet_a : assert property (go && burst_active && !stb && !global_write_all_n
		|=> dq_oe_n)
		else $error("bus driven after a write edge");
	sleep_sync_a : assert property ((sleep_request && clk_en) [*2] |=> sleep_active)
		else $error("sleep request not seen in two edges");
	sleep_end_a : assert property (sleep_active [*2] |-> !burst_active)
		else $error("burst open during sleep");
endmodule

bind pbsp_port pbsp_chk i_pbsp_chk (.core_clk, .rstn, .clk_en, .processor_addr_strobe_n,
	.controller_addr_strobe_n, .byte_write_gate_n, .global_write_all_n, .chip_select_one_n,
	.chip_select_two, .chip_select_three_n, .output_enable_n, .sleep_request, .dq_oe_n,
	.sleep_active, .burst_active);

// [bench/pbsp_host.sv]
// Bus-side model: runs bursts on the port and notes the read data it expects
`timescale 1ns/1ps
module pbsp_host
(
	input  logic                  core_clk,
	output pbsp_pkg::pbsp_addr_t  addr,
	output logic                  processor_addr_strobe_n,
	output logic                  controller_addr_strobe_n,
	output logic                  burst_advance_n,
	output pbsp_pkg::pbsp_lanes_t byte_lane_select_n,
	output logic                  byte_write_gate_n,
	output logic                  global_write_all_n,
	output logic                  chip_select_one_n,
	output logic                  chip_select_two,
	output logic                  chip_select_three_n,
	output logic                  output_enable_n,
	output logic                  order_select,
	output pbsp_pkg::pbsp_word_t  dq_in
);
	import pbsp_pkg::*;
	pbsp_word_t mem [pbsp_addr_t];
	pbsp_word_t exp_q [$];
	logic       order;
	// Pins change only just after an edge so they are set up for the next one
	task automatic tick();
		@(posedge core_clk);
		#1;
	endtask
	// Idle: no strobe, no write, select one high; released data never keeps its value
	task automatic idle();
		{processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n} = 3'h7;
		{byte_write_gate_n, global_write_all_n, byte_lane_select_n} = 6'h3f;
		{chip_select_one_n, chip_select_two, chip_select_three_n} = 3'h6;
		dq_in = ~dq_in;
	endtask
	task automatic set_order(bit o);
		order_select = o;
		order = o;
		repeat (4) tick();
	endtask
	// Strobe, four steps (one held first if asked), then a deselecting strobe
	task automatic burst(pbsp_addr_t a, bit wr, bit gw, pbsp_lanes_t bw, bit hold);
		pbsp_addr_t p;
		pbsp_word_t d;
		int         s;
		tick();
		addr = a;
		{chip_select_one_n, chip_select_two, chip_select_three_n} = 3'h2;
		// One strobe or both at once, picked at random
		s = $urandom % 3;
		controller_addr_strobe_n = (s == 1);
		processor_addr_strobe_n = (s == 0);
		for (int k = 0; k < 4 + hold; k++)
		begin
			tick();
			{processor_addr_strobe_n, controller_addr_strobe_n} = 2'h3;
			addr = ~a;
			burst_advance_n = (k < hold);
			s = (k > hold) ? k - hold : 0;
			p = {a[15:2], order ? a[1:0] ^ 2'(s) : a[1:0] + 2'(s)};
			d = $urandom;
			dq_in = d;
			output_enable_n = wr;
			if (wr)
			begin
				global_write_all_n = !gw;
				byte_write_gate_n = 1'b0;
				byte_lane_select_n = bw;
				for (int i = 0; i < 4; i++)
					if (gw || !bw[i])
						mem[p][8*i +: 8] = d[8*i +: 8];
			end
			else if (k > 0)
				exp_q.push_back(mem[p]);
		end
		close();
	endtask
	// Deselecting strobe closes whatever burst is open
	task automatic close();
		tick();
		idle();
		controller_addr_strobe_n = 1'b0;
		tick();
		controller_addr_strobe_n = 1'b1;
		output_enable_n = 1'b1;
	endtask
	// Open a burst, then a processor strobe with select one high; the burst must stay open
	task automatic ghost();
		tick();
		{chip_select_one_n, chip_select_two, chip_select_three_n} = 3'h2;
		controller_addr_strobe_n = 1'b0;
		tick();
		idle();
		processor_addr_strobe_n = 1'b0;
		tick();
		processor_addr_strobe_n = 1'b1;
	endtask
	initial
	begin
		idle();
		dq_in = 32'h0;
		addr = 16'h0;
		output_enable_n = 1'b1;
		order = 1'b1;
		order_select = 1'b1;
	end
endmodule

// [bench/pbsp_port_tb.sv]
// Self-checking bench for the burst SRAM port
`timescale 1ns/1ps
module pbsp_port_tb;
	import pbsp_pkg::*;
	logic core_clk = 1'b0;
	logic rstn, sleep_request, processor_addr_strobe_n, controller_addr_strobe_n;
	logic burst_advance_n, byte_write_gate_n, global_write_all_n, chip_select_one_n;
	logic chip_select_two, chip_select_three_n, output_enable_n, order_select;
	logic dq_oe_n, sleep_active, burst_active;
	pbsp_addr_t  addr, a;
	pbsp_lanes_t byte_lane_select_n;
	pbsp_word_t  dq_in, dq_out;
	int          fails = 0;
	int          checks = 0;
	always #20 core_clk = ~core_clk;
	pbsp_port i_pbsp_port (.core_clk, .rstn, .clk_en(1'b1), .addr, .processor_addr_strobe_n,
		.controller_addr_strobe_n, .burst_advance_n, .byte_lane_select_n, .byte_write_gate_n,
		.global_write_all_n, .chip_select_one_n, .chip_select_two, .chip_select_three_n,
		.output_enable_n, .order_select, .sleep_request, .dq_in, .dq_out, .dq_oe_n,
		.sleep_active, .burst_active);
	pbsp_host i_pbsp_host (.core_clk, .addr, .processor_addr_strobe_n, .controller_addr_strobe_n,
		.burst_advance_n, .byte_lane_select_n, .byte_write_gate_n, .global_write_all_n,
		.chip_select_one_n, .chip_select_two, .chip_select_three_n, .output_enable_n,
		.order_select, .dq_in);
	task automatic tally_and_finish();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Any driven cycle consumes the oldest expected word; an empty queue is a fault
	// Sampled mid-cycle, where the registered outputs have settled
	always @(negedge core_clk)
		if (dq_oe_n === 1'b0)
		begin
			checks++;
			if (i_pbsp_host.exp_q.size() == 0 || dq_out !== i_pbsp_host.exp_q.pop_front())
			begin
				$display("CHECK FAILED at %0t: unexpected read data %h", $time, dq_out);
				fails++;
			end
		end
	initial
	begin
		#80000;
		fails++;
		tally_and_finish();
	end
	initial
	begin
		rstn = 1'b0;
		sleep_request = 1'b0;
		void'($urandom(32'h901463da));
		repeat (20) @(posedge core_clk);
		#1 rstn = 1'b1;
		for (int o = 0; o < 2; o++)
		begin
			a = $urandom;
			i_pbsp_host.set_order(o[0]);
			i_pbsp_host.burst(a, 1, 1, 4'hf, 0);
			i_pbsp_host.burst(a, 0, 0, 4'h0, 0);
			i_pbsp_host.burst(a, 1, 0, pbsp_lanes_t'($urandom), 0);
			i_pbsp_host.burst(a, 0, 0, 4'h0, 1);
			i_pbsp_host.ghost();
			checks++;
			if (burst_active !== 1'b1)
			begin
				$display("CHECK FAILED at %0t: processor strobe taken with select one high", $time);
				fails++;
			end
			i_pbsp_host.close();
			$display("burst tests done for order %0d", o);
		end
		// Sleep ends an open burst and keeps the array; the later read proves it
		i_pbsp_host.ghost();
		sleep_request = 1'b1;
		repeat (4) @(posedge core_clk);
		#1;
		checks++;
		if (sleep_active !== 1'b1 || burst_active !== 1'b0)
		begin
			$display("CHECK FAILED at %0t: sleep not entered", $time);
			fails++;
		end
		sleep_request = 1'b0;
		repeat (4) @(posedge core_clk);
		#1;
		i_pbsp_host.burst(a, 0, 0, 4'h0, 0);
		$display("sleep test done");
		checks++;
		if (i_pbsp_host.exp_q.size() != 0)
		begin
			$display("CHECK FAILED at %0t: reads never driven", $time);
			fails++;
		end
		tally_and_finish();
	end
endmodule
